//--- adc_event_flags_and_align_test.sv
`timescale 1ns/1ps
`include "adcefa_defines.vh"
module adc_event_flags_and_align_test;
   reg clk_sys_in, resetn_in, reg_wr_in, reg_rd_in, conv_done_in, conv_last_in, wait_mode_in, halt_mode_in;
   reg [7:0] reg_addr_in, reg_wdata_in;
   reg [9:0] conv_data_in;
   reg [3:0] conv_index_in;
   wire [7:0] reg_rdata_out;
   wire conv_halt_out, wake_out, irq_out;
   integer n_fail, checks_done, k;
   adcefa_top u_adcefa_top (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr_in),
      .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
      .conv_done_in(conv_done_in), .conv_data_in(conv_data_in), .conv_index_in(conv_index_in),
      .conv_last_in(conv_last_in), .conv_halt_out(conv_halt_out), .wait_mode_in(wait_mode_in),
      .halt_mode_in(halt_mode_in), .wake_out(wake_out), .irq_out(irq_out));
   initial begin
      clk_sys_in = 1'b0;
      forever #5 clk_sys_in = ~clk_sys_in;
   end
   task check(input string name, input [7:0] seen, input [7:0] exp);
      begin
         checks_done = checks_done + 1;
         if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("Error %s expected %h seen %h", name, exp, seen);
         end
      end
   endtask
   task wr(input [7:0] a, input [7:0] d);
      begin
         @(posedge clk_sys_in);
         reg_wr_in <= 1'b1;
         reg_addr_in <= a;
         reg_wdata_in <= d;
         @(posedge clk_sys_in);
         reg_wr_in <= 1'b0;
         #1;
      end
   endtask
   task rd(input [7:0] a, input [7:0] e);
      begin
         @(posedge clk_sys_in);
         reg_rd_in <= 1'b1;
         reg_addr_in <= a;
         @(posedge clk_sys_in);
         reg_rd_in <= 1'b0;
         #1;
         check($sformatf("register %h", a), reg_rdata_out, e);
      end
   endtask
   task cv(input [9:0] d, input [3:0] i, input l);
      begin
         @(posedge clk_sys_in);
         conv_done_in <= 1'b1;
         conv_data_in <= d;
         conv_index_in <= i;
         conv_last_in <= l;
         @(posedge clk_sys_in);
         conv_done_in <= 1'b0;
         #1;
      end
   endtask
   task t_reset;
      begin
         rd(`ADCEFA_REG_CTRL, 8'h00);
         rd(`ADCEFA_REG_IRQ_MASK, 8'h03);
         rd(`ADCEFA_REG_HTHR_LO, 8'hff);
         rd(`ADCEFA_REG_HTHR_HI, 8'h03);
         rd(`ADCEFA_REG_LTHR_LO, 8'h00);
         rd(`ADCEFA_REG_FLAGS, 8'h00);
         rd(8'h0e, 8'h00);
      end
   endtask
   task t_align;
      begin
         wr(`ADCEFA_REG_CTRL, 8'h00);
         cv(10'h2b5, 4'h0, 1'b0);
         rd(`ADCEFA_REG_RES_LO, 8'hb5);
         rd(`ADCEFA_REG_RES_HI, 8'h02);
         cv(10'h2b5, 4'h0, 1'b0);
         rd(`ADCEFA_REG_RES_LO, 8'hb5);
         cv(10'h1c3, 4'h0, 1'b0);
         rd(`ADCEFA_REG_RES_HI, 8'h02);
         rd(`ADCEFA_REG_RES_HI, 8'h01);
         wr(`ADCEFA_REG_CTRL, 8'h01);
         cv(10'h2b5, 4'h0, 1'b0);
         rd(`ADCEFA_REG_RES_HI, 8'had);
         cv(10'h0c0, 4'h0, 1'b0);
         rd(`ADCEFA_REG_RES_LO, 8'h40);
         rd(`ADCEFA_REG_RES_LO, 8'h00);
      end
   endtask
   task buf_round(input [7:0] ctrl);
      begin
         wr(`ADCEFA_REG_FLAGS, 8'h00);
         wr(`ADCEFA_REG_WDST_LO, 8'h00);
         wr(`ADCEFA_REG_CTRL, ctrl);
         for (k = 0; k < 9; k = k + 1)
            cv((k == 2 || k == 3) ? 10'h300 : 10'h100, k[3:0], 1'b0);
         rd(`ADCEFA_REG_FLAGS, 8'h00);
         check("irq early", {7'h00, irq_out}, 8'h00);
         cv(10'h100, 4'h9, 1'b0);
         check("irq full", {7'h00, irq_out}, 8'h01);
         rd(`ADCEFA_REG_FLAGS, 8'h03);
         rd(`ADCEFA_REG_WDST_LO, 8'h04);
      end
   endtask
   task t_buffered;
      begin
         wr(`ADCEFA_REG_WDEN_LO, 8'h04);
         wr(`ADCEFA_REG_WDEN_HI, 8'h00);
         wr(`ADCEFA_REG_HTHR_LO, 8'h00);
         wr(`ADCEFA_REG_HTHR_HI, 8'h02);
         buf_round(8'h0c);
         wr(`ADCEFA_REG_IRQ_MASK, 8'h00);
         check("irq masked", {7'h00, irq_out}, 8'h00);
         wr(`ADCEFA_REG_IRQ_MASK, 8'h03);
         rd(`ADCEFA_REG_IRQ_STAT, 8'h01);
         check("irq read", {7'h00, irq_out}, 8'h00);
         wr(`ADCEFA_REG_FLAGS, 8'hff);
         rd(`ADCEFA_REG_FLAGS, 8'h03);
         wr(`ADCEFA_REG_FLAGS, 8'h02);
         rd(`ADCEFA_REG_FLAGS, 8'h02);
         rd(8'h14, 8'h03);
         buf_round(8'h14);
         rd(`ADCEFA_REG_IRQ_STAT, 8'h02);
         check("halt", {7'h00, conv_halt_out}, 8'h00);
      end
   endtask
   task t_scan;
      begin
         wr(`ADCEFA_REG_FLAGS, 8'h00);
         wr(`ADCEFA_REG_WDST_LO, 8'h00);
         wr(`ADCEFA_REG_WDEN_LO, 8'h02);
         wr(`ADCEFA_REG_CTRL, 8'h0a);
         cv(10'h100, 4'h0, 1'b0);
         cv(10'h300, 4'h1, 1'b0);
         cv(10'h100, 4'h2, 1'b0);
         rd(`ADCEFA_REG_FLAGS, 8'h00);
         cv(10'h100, 4'h3, 1'b1);
         check("irq scan", {7'h00, irq_out}, 8'h01);
         rd(`ADCEFA_REG_FLAGS, 8'h03);
         rd(`ADCEFA_REG_WDST_LO, 8'h02);
         rd(`ADCEFA_REG_IRQ_STAT, 8'h01);
      end
   endtask
   task t_halt;
      begin
         wr(`ADCEFA_REG_FLAGS, 8'h00);
         wr(`ADCEFA_REG_WDST_LO, 8'h00);
         wr(`ADCEFA_REG_CTRL, 8'h1a);
         cv(10'h100, 4'h0, 1'b0);
         cv(10'h300, 4'h1, 1'b0);
         rd(`ADCEFA_REG_FLAGS, 8'h02);
         check("halt set", {7'h00, conv_halt_out}, 8'h01);
         cv(10'h100, 4'h2, 1'b1);
         rd(`ADCEFA_REG_FLAGS, 8'h02);
         @(posedge clk_sys_in);
         wait_mode_in <= 1'b1;
         #1;
         check("wake wait", {7'h00, wake_out}, 8'h01);
         @(posedge clk_sys_in);
         halt_mode_in <= 1'b1;
         #1;
         check("wake halt", {7'h00, wake_out}, 8'h00);
         rd(`ADCEFA_REG_IRQ_STAT, 8'h02);
         wr(`ADCEFA_REG_FLAGS, 8'h00);
         @(posedge clk_sys_in);
         #1;
         check("halt clear", {7'h00, conv_halt_out}, 8'h00);
      end
   endtask
   task print_verdict;
      begin
         $display("Mismatches %0d, comparisons %0d", n_fail, checks_done);
         if (n_fail == 0 && checks_done > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask
   initial begin
      n_fail = 0;
      checks_done = 0;
      resetn_in = 1'b0;
      {reg_wr_in, reg_rd_in, conv_done_in, conv_last_in, wait_mode_in, halt_mode_in} = 6'h00;
      reg_addr_in = 8'h00;
      reg_wdata_in = 8'h00;
      conv_data_in = 10'h000;
      conv_index_in = 4'h0;
      repeat (5) @(posedge clk_sys_in);
      resetn_in <= 1'b1;
      t_reset;
      t_align;
      t_buffered;
      t_scan;
      t_halt;
      print_verdict;
   end
   initial begin
      #100000;
      n_fail = n_fail + 1;
      print_verdict;
   end
endmodule
bind adcefa_top adcefa_monitor #(.DEPTH(DEPTH), .DATA_W(DATA_W)) u_adcefa_monitor (.clk_sys_in(clk_sys_in),
   .resetn_in(resetn_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
   .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .conv_done_in(conv_done_in), .conv_data_in(conv_data_in),
   .conv_index_in(conv_index_in), .conv_last_in(conv_last_in), .conv_halt_out(conv_halt_out),
   .wait_mode_in(wait_mode_in), .halt_mode_in(halt_mode_in), .wake_out(wake_out), .irq_out(irq_out));

//--- adcefa_align.v
`timescale 1ns/1ps
`include "adcefa_defines.vh"

module adcefa_align #(
   parameter DATA_W = `ADCEFA_DATA_W_DEF
) (
   // Control
   input wire left_in,
   // Result
   input wire [DATA_W-1:0] data_in,
   // Split bytes
   output wire [7:0] hi_out,
   output wire [7:0] lo_out
);

   wire [15:0] right_word;
   wire [15:0] left_word;
   wire [15:0] sel_word;

   assign right_word = {{(16-DATA_W){1'b0}}, data_in};
   assign left_word = {data_in, {(16-DATA_W){1'b0}}};
   assign sel_word = left_in ? left_word : right_word;
   assign hi_out = sel_word[15:8];
   assign lo_out = sel_word[7:0];

endmodule

//--- adcefa_defines.vh
`ifndef ADCEFA_DEFINES_VH
`define ADCEFA_DEFINES_VH

// Register offsets on the local register port.
`define ADCEFA_REG_CTRL 8'h00
`define ADCEFA_REG_FLAGS 8'h01
`define ADCEFA_REG_IRQ_STAT 8'h02
`define ADCEFA_REG_IRQ_MASK 8'h03
`define ADCEFA_REG_WDEN_LO 8'h04
`define ADCEFA_REG_WDEN_HI 8'h05
`define ADCEFA_REG_WDST_LO 8'h06
`define ADCEFA_REG_WDST_HI 8'h07
`define ADCEFA_REG_HTHR_LO 8'h08
`define ADCEFA_REG_HTHR_HI 8'h09
`define ADCEFA_REG_LTHR_LO 8'h0a
`define ADCEFA_REG_LTHR_HI 8'h0b
`define ADCEFA_REG_RES_HI 8'h0c
`define ADCEFA_REG_RES_LO 8'h0d
`define ADCEFA_REG_BUF_BASE 8'h10

// Control register fields.
`define ADCEFA_CTRL_ALIGN_LEFT 0
`define ADCEFA_CTRL_SCAN 1
`define ADCEFA_CTRL_BUFFERED 2
`define ADCEFA_CTRL_DONE_IE 3
`define ADCEFA_CTRL_WD_IE 4

// Flag register and interrupt status fields.
`define ADCEFA_FLAG_DONE 0
`define ADCEFA_FLAG_WD 1

// Reset values.
`define ADCEFA_CTRL_RST 8'h00
`define ADCEFA_IRQ_MASK_RST 2'h3
`define ADCEFA_HTHR_RST 10'h3ff
`define ADCEFA_LTHR_RST 10'h000

// Sizes.
`define ADCEFA_BUF_DEPTH_DEF 10
`define ADCEFA_DATA_W_DEF 10

`endif

//--- adcefa_irq.v
`timescale 1ns/1ps
`include "adcefa_defines.vh"

module adcefa_irq (
   // Clock and reset
   input wire clk_sys_in,
   input wire resetn_in,
   // Events
   input wire [1:0] set_in,
   input wire rd_clr_in,
   // Mask
   input wire mask_we_in,
   input wire [1:0] mask_wdata_in,
   // State
   output wire [1:0] stat_out,
   output wire [1:0] mask_out,
   output wire irq_out
);

   reg [1:0] stat_q;
   reg [1:0] mask_q;
   wire [1:0] stat_d;

   // A set in the cycle of the clearing read survives.
   assign stat_d = set_in | (rd_clr_in ? 2'h0 : stat_q);

   always @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         stat_q <= 2'h0;
         mask_q <= `ADCEFA_IRQ_MASK_RST;
      end else begin
         stat_q <= stat_d;
         if (mask_we_in) begin
            mask_q <= mask_wdata_in;
         end
      end
   end

   assign stat_out = stat_q;
   assign mask_out = mask_q;
   assign irq_out = |(stat_q & mask_q);

endmodule

//--- adcefa_monitor.sv
`timescale 1ns/1ps
`include "adcefa_defines.vh"
module adcefa_monitor #(
   parameter DEPTH = 10,
   parameter DATA_W = 10
) (
   // Clock and reset
   input wire clk_sys_in,
   input wire resetn_in,
   // Register port
   input wire [7:0] reg_addr_in,
   input wire [7:0] reg_wdata_in,
   input wire reg_wr_in,
   input wire reg_rd_in,
   input wire [7:0] reg_rdata_out,
   // Converter core
   input wire conv_done_in,
   input wire [DATA_W-1:0] conv_data_in,
   input wire [3:0] conv_index_in,
   input wire conv_last_in,
   input wire conv_halt_out,
   // Power management
   input wire wait_mode_in,
   input wire halt_mode_in,
   input wire wake_out,
   input wire irq_out
);
   reg [7:0] ctrl_q;
   reg [1:0] mask_q;
   reg [4:0] cnt_q;
   wire acc = conv_done_in & ~conv_halt_out;
   wire ctrl_wr = reg_wr_in && reg_addr_in == `ADCEFA_REG_CTRL;
   wire buf_on = ctrl_q[`ADCEFA_CTRL_BUFFERED] & ~ctrl_q[`ADCEFA_CTRL_SCAN];
   wire done_ie = ctrl_q[`ADCEFA_CTRL_DONE_IE] & mask_q[0];
   // Shadow of control, mask and the buffer fill count, seen from the bus.
   always @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         ctrl_q <= `ADCEFA_CTRL_RST;
         mask_q <= `ADCEFA_IRQ_MASK_RST;
         cnt_q <= 5'h00;
      end else begin
         if (ctrl_wr)
            ctrl_q <= reg_wdata_in;
         if (reg_wr_in && reg_addr_in == `ADCEFA_REG_IRQ_MASK)
            mask_q <= reg_wdata_in[1:0];
         if (ctrl_wr || !buf_on)
            cnt_q <= 5'h00;
         else if (acc)
            cnt_q <= (cnt_q == DEPTH - 1) ? 5'h00 : cnt_q + 5'h01;
      end
   end
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (!resetn_in);
   property p_wake;
      wake_out == (irq_out & wait_mode_in & ~halt_mode_in);
   endproperty
   a_wake: assert property (p_wake) else $error("wake output wrong");
   property p_rd_idle;
      !$past(reg_rd_in) |-> reg_rdata_out == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
   property p_irq_rise;
      $rose(irq_out) |-> $past(conv_done_in) || $past(reg_wr_in);
   endproperty
   a_irq_rise: assert property (p_irq_rise) else $error("interrupt rose without cause");
   property p_irq_fall;
      $fell(irq_out) |-> $past(reg_wr_in) || $past(reg_rd_in && reg_addr_in == `ADCEFA_REG_IRQ_STAT);
   endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("interrupt fell without cause");
   property p_irq_mask;
      irq_out |-> mask_q != 2'h0;
   endproperty
   a_irq_mask: assert property (p_irq_mask) else $error("interrupt while fully masked");
   property p_scan_done;
      acc && conv_last_in && ctrl_q[`ADCEFA_CTRL_SCAN] && done_ie |=> irq_out;
   endproperty
   a_scan_done: assert property (p_scan_done) else $error("no interrupt at scan end");
   property p_buf_full;
      acc && buf_on && cnt_q == DEPTH - 1 && done_ie |=> irq_out;
   endproperty
   a_buf_full: assert property (p_buf_full) else $error("no interrupt at buffer full");
   property p_halt;
      $rose(conv_halt_out) |-> ($past(conv_done_in) || $past(conv_done_in, 2))
         && $past(ctrl_q[`ADCEFA_CTRL_DONE_IE] && ctrl_q[`ADCEFA_CTRL_WD_IE]);
   endproperty
   a_halt: assert property (p_halt) else $error("halt without cause");
   c_full: cover property (acc && buf_on && cnt_q == DEPTH - 1);
   c_halt: cover property ($rose(conv_halt_out));
   c_wake: cover property (wake_out);
endmodule

//--- adcefa_top.v
// Contract
// - A software control bit selects how each result is split over two bytes.
// - Right justified: low byte holds 8 LSBs, high byte the rest, zero filled.
// - Left justified: high byte holds 8 MSBs, low byte upper bits hold the rest.
// - Buffered mode sets conversion done only when the whole buffer is filled.
// - Scan mode sets conversion done once, after the last channel is converted.
// - With done interrupt enabled, an interrupt is raised when done is set.
// - An enabled entry sets its watchdog status when outside the threshold window.
// - Buffered mode without both enables sets watchdog flag at buffer full.
// - Scan mode without both enables sets watchdog flag at scan end.
// - Both enables set: watchdog flag on first hit, interrupt, conversion halts.
// - Buffer depth is 8 or 10 entries and marks the buffer full point.
// - Done flag stays set until software writes zero to it; one has no effect.
// - The conversion result is 10 bits wide.
//
// Chosen here: the address map and the strobed register port.
`timescale 1ns/1ps
`include "adcefa_defines.vh"

module adcefa_top #(
   parameter DEPTH = `ADCEFA_BUF_DEPTH_DEF,
   parameter DATA_W = `ADCEFA_DATA_W_DEF
) (
   // Clock and reset
   input wire clk_sys_in,
   input wire resetn_in,
   // Register port
   input wire [7:0] reg_addr_in,
   input wire [7:0] reg_wdata_in,
   input wire reg_wr_in,
   input wire reg_rd_in,
   output wire [7:0] reg_rdata_out,
   // Converter core
   input wire conv_done_in,
   input wire [DATA_W-1:0] conv_data_in,
   input wire [3:0] conv_index_in,
   input wire conv_last_in,
   output wire conv_halt_out,
   // Power management
   input wire wait_mode_in,
   input wire halt_mode_in,
   output wire wake_out,
   output wire irq_out
);

   localparam [31:0] LAST_FULL = DEPTH - 1;
   localparam [3:0] LAST_ENTRY = LAST_FULL[3:0];

   // Returns a one-hot entry mask, or zero for an index beyond the buffer.
   function [15:0] entry_bit;
      input [3:0] idx;
      begin
         entry_bit = 16'h0000;
         if (idx <= LAST_ENTRY) begin
            entry_bit[idx] = 1'b1;
         end
      end
   endfunction

   // Returns the buffer entry addressed by a byte offset.
   function [3:0] buf_entry;
      input [7:0] addr;
      reg [7:0] rel;
      begin
         rel = addr - `ADCEFA_REG_BUF_BASE;
         buf_entry = rel[4:1];
      end
   endfunction

   // Tells whether a byte offset falls inside the buffer window.
   function buf_hit;
      input [7:0] addr;
      reg [7:0] rel;
      begin
         rel = addr - `ADCEFA_REG_BUF_BASE;
         buf_hit = (addr >= `ADCEFA_REG_BUF_BASE) && (rel[7:5] == 3'h0) && (rel[4:1] <= LAST_ENTRY);
      end
   endfunction

   // Control and configuration.
   reg [7:0] ctrl_q;
   reg [15:0] wden_q;
   reg [15:0] wdst_q;
   reg [DATA_W-1:0] hthr_q;
   reg [DATA_W-1:0] lthr_q;
   reg done_q;
   reg wdflag_q;
   reg halt_q;
   reg [3:0] cnt_q;
   reg [7:0] res_hi_q;
   reg [7:0] res_lo_q;
   reg [7:0] shadow_q;
   reg lock_q;
   reg [7:0] rdata_q;
   reg [7:0] buf_hi_q [0:DEPTH-1];
   reg [7:0] buf_lo_q [0:DEPTH-1];

   wire align_left;
   wire scan_mode;
   wire buf_mode;
   wire multi_mode;
   wire done_ie;
   wire wd_ie;
   wire both_ie;
   wire [7:0] split_hi;
   wire [7:0] split_lo;
   wire [1:0] irq_stat;
   wire [1:0] irq_mask;

   assign align_left = ctrl_q[`ADCEFA_CTRL_ALIGN_LEFT];
   assign scan_mode = ctrl_q[`ADCEFA_CTRL_SCAN];
   assign buf_mode = ctrl_q[`ADCEFA_CTRL_BUFFERED] & ~scan_mode;
   assign multi_mode = scan_mode | buf_mode;
   assign done_ie = ctrl_q[`ADCEFA_CTRL_DONE_IE];
   assign wd_ie = ctrl_q[`ADCEFA_CTRL_WD_IE];
   assign both_ie = done_ie & wd_ie;

   // Register port decode.
   wire wr_ctrl;
   wire wr_flags;
   wire wr_wdst_lo;
   wire wr_wdst_hi;
   wire rd_res_hi;
   wire rd_res_lo;

   assign wr_ctrl = reg_wr_in && (reg_addr_in == `ADCEFA_REG_CTRL);
   assign wr_flags = reg_wr_in && (reg_addr_in == `ADCEFA_REG_FLAGS);
   assign wr_wdst_lo = reg_wr_in && (reg_addr_in == `ADCEFA_REG_WDST_LO);
   assign wr_wdst_hi = reg_wr_in && (reg_addr_in == `ADCEFA_REG_WDST_HI);
   assign rd_res_hi = reg_rd_in && (reg_addr_in == `ADCEFA_REG_RES_HI);
   assign rd_res_lo = reg_rd_in && (reg_addr_in == `ADCEFA_REG_RES_LO);

   // Conversion event handling.
   wire evt;
   wire [3:0] idx;
   wire [15:0] idx_bit;
   wire out_win;
   wire hit;
   wire [15:0] wdst_set;
   wire [15:0] wdst_new;
   wire end_seq;
   wire done_set;
   wire wdflag_set;
   wire halt_set;
   wire done_clr;
   wire wdflag_clr;
   wire [15:0] wdst_clr;

   // A halted sequence takes no further results.
   assign evt = conv_done_in & ~halt_q;
   assign idx = buf_mode ? cnt_q : (scan_mode ? conv_index_in : 4'h0);
   assign idx_bit = entry_bit(idx);
   assign out_win = (conv_data_in > hthr_q) || (conv_data_in < lthr_q);
   assign hit = evt & multi_mode & out_win & |(wden_q & idx_bit);
   assign wdst_set = hit ? idx_bit : 16'h0000;
   assign wdst_new = wdst_q | wdst_set;

   // The end point is buffer full, scan end, or every single conversion.
   assign end_seq = evt & (buf_mode ? (cnt_q == LAST_ENTRY) : (scan_mode ? conv_last_in : 1'b1));
   assign done_set = end_seq;

   // With both enables the flag fires on the first hit, otherwise at the end point.
   assign wdflag_set = multi_mode ?
                    (both_ie ? hit : (end_seq & |wdst_new)) :
                    (evt & out_win);
   assign halt_set = multi_mode & both_ie & hit;

   assign done_clr = wr_flags & ~reg_wdata_in[`ADCEFA_FLAG_DONE];
   assign wdflag_clr = wr_flags & ~reg_wdata_in[`ADCEFA_FLAG_WD];
   assign wdst_clr = {(wr_wdst_hi ? ~reg_wdata_in : 8'h00), (wr_wdst_lo ? ~reg_wdata_in : 8'h00)};

   adcefa_align #(
      .DATA_W(DATA_W)
   ) u_align (
      .left_in(align_left),
      .data_in(conv_data_in),
      .hi_out(split_hi),
      .lo_out(split_lo)
   );

   adcefa_irq u_irq (
      .clk_sys_in(clk_sys_in),
      .resetn_in(resetn_in),
      .set_in({wdflag_set & wd_ie, done_set & done_ie}),
      .rd_clr_in(reg_rd_in && (reg_addr_in == `ADCEFA_REG_IRQ_STAT)),
      .mask_we_in(reg_wr_in && (reg_addr_in == `ADCEFA_REG_IRQ_MASK)),
      .mask_wdata_in(reg_wdata_in[1:0]),
      .stat_out(irq_stat),
      .mask_out(irq_mask),
      .irq_out(irq_out)
   );

   // Configuration registers: control, watchdog enables and thresholds.
   always @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         ctrl_q <= `ADCEFA_CTRL_RST;
         wden_q <= 16'h0000;
         hthr_q <= `ADCEFA_HTHR_RST;
         lthr_q <= `ADCEFA_LTHR_RST;
      end else if (reg_wr_in) begin
         case (reg_addr_in)
            `ADCEFA_REG_CTRL: begin
               ctrl_q <= {3'h0, reg_wdata_in[4:0]};
            end
            `ADCEFA_REG_WDEN_LO: begin
               wden_q[7:0] <= reg_wdata_in;
            end
            `ADCEFA_REG_WDEN_HI: begin
               wden_q[15:8] <= reg_wdata_in;
            end
            `ADCEFA_REG_HTHR_LO: begin
               hthr_q[7:0] <= reg_wdata_in;
            end
            `ADCEFA_REG_HTHR_HI: begin
               hthr_q[DATA_W-1:8] <= reg_wdata_in[DATA_W-9:0];
            end
            `ADCEFA_REG_LTHR_LO: begin
               lthr_q[7:0] <= reg_wdata_in;
            end
            `ADCEFA_REG_LTHR_HI: begin
               lthr_q[DATA_W-1:8] <= reg_wdata_in[DATA_W-9:0];
            end
            default: begin
               ctrl_q <= ctrl_q;
            end
         endcase
      end
   end

   // Flags: a set in the same cycle as a clear wins.
   always @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         done_q <= 1'b0;
         wdflag_q <= 1'b0;
         halt_q <= 1'b0;
         wdst_q <= 16'h0000;
         cnt_q <= 4'h0;
      end else begin
         done_q <= done_set | (done_q & ~done_clr);
         wdflag_q <= wdflag_set | (wdflag_q & ~wdflag_clr);
         wdst_q <= wdst_set | (wdst_q & ~wdst_clr);
         // Halt releases when software clears the watchdog flag or leaves the mode.
         halt_q <= halt_set | (halt_q & ~wdflag_clr & multi_mode & both_ie);
         if (!buf_mode || wr_ctrl) begin
            cnt_q <= 4'h0;
         end else if (evt) begin
            cnt_q <= (cnt_q == LAST_ENTRY) ? 4'h0 : cnt_q + 4'h1;
         end
      end
   end

   // Result bytes, split at the moment the conversion completes.
   always @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         res_hi_q <= 8'h00;
         res_lo_q <= 8'h00;
      end else if (evt) begin
         res_hi_q <= split_hi;
         res_lo_q <= split_lo;
      end
   end

   // Buffer entries hold no reset value; software reads them after done.
   always @(posedge clk_sys_in) begin
      if (evt && multi_mode && (idx <= LAST_ENTRY)) begin
         buf_hi_q[idx] <= split_hi;
         buf_lo_q[idx] <= split_lo;
      end
   end

   // Reading the first byte of a pair freezes its partner until the second read.
   always @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         shadow_q <= 8'h00;
         lock_q <= 1'b0;
      end else if (align_left ? rd_res_hi : rd_res_lo) begin
         shadow_q <= align_left ? res_lo_q : res_hi_q;
         lock_q <= 1'b1;
      end else if (align_left ? rd_res_lo : rd_res_hi) begin
         lock_q <= 1'b0;
      end
   end

   // Read multiplexer.
   reg [7:0] rd_mux;
   reg [3:0] rd_entry;

   always @* begin
      rd_mux = 8'h00;
      rd_entry = buf_entry(reg_addr_in);
      case (reg_addr_in)
         `ADCEFA_REG_CTRL: begin
            rd_mux = ctrl_q;
         end
         `ADCEFA_REG_FLAGS: begin
            rd_mux = {6'h00, wdflag_q, done_q};
         end
         `ADCEFA_REG_IRQ_STAT: begin
            rd_mux = {6'h00, irq_stat};
         end
         `ADCEFA_REG_IRQ_MASK: begin
            rd_mux = {6'h00, irq_mask};
         end
         `ADCEFA_REG_WDEN_LO: begin
            rd_mux = wden_q[7:0];
         end
         `ADCEFA_REG_WDEN_HI: begin
            rd_mux = wden_q[15:8];
         end
         `ADCEFA_REG_WDST_LO: begin
            rd_mux = wdst_q[7:0];
         end
         `ADCEFA_REG_WDST_HI: begin
            rd_mux = wdst_q[15:8];
         end
         `ADCEFA_REG_HTHR_LO: begin
            rd_mux = hthr_q[7:0];
         end
         `ADCEFA_REG_HTHR_HI: begin
            rd_mux = {{(16-DATA_W){1'b0}}, hthr_q[DATA_W-1:8]};
         end
         `ADCEFA_REG_LTHR_LO: begin
            rd_mux = lthr_q[7:0];
         end
         `ADCEFA_REG_LTHR_HI: begin
            rd_mux = {{(16-DATA_W){1'b0}}, lthr_q[DATA_W-1:8]};
         end
         `ADCEFA_REG_RES_HI: begin
            rd_mux = (lock_q && !align_left) ? shadow_q : res_hi_q;
         end
         `ADCEFA_REG_RES_LO: begin
            rd_mux = (lock_q && align_left) ? shadow_q : res_lo_q;
         end
         default: begin
            if (buf_hit(reg_addr_in)) begin
               rd_mux = reg_addr_in[0] ? buf_lo_q[rd_entry] : buf_hi_q[rd_entry];
            end
         end
      endcase
   end

   // Read data stand only in the cycle after the read strobe.
   always @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= reg_rd_in ? rd_mux : 8'h00;
      end
   end

   assign reg_rdata_out = rdata_q;
   assign conv_halt_out = halt_q;
   assign wake_out = irq_out & wait_mode_in & ~halt_mode_in;

endmodule
